//--- fsp_defines.vh
// constants for the sector-protection command sequencer
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

// clock rate and time-to-cycle rounding (least times round up)
`define FSP_CLK_MHZ 250
`define FSP_CYC_UP(ns) ((((ns) * `FSP_CLK_MHZ) + 999) / 1000)

// bus timing in ns
`define FSP_T_WP_NS 35
`define FSP_T_REC_NS 20
`define FSP_T_ACC_NS 110
`define FSP_T_UNLOCK_NS 2000
// waits after program and bulk erase, in cycles (plain defaults)
`define FSP_PROG_WAIT_CYC 50000
`define FSP_ERASE_WAIT_CYC 2000000

// user operations
`define FSP_OP_ENTER 4'h0
`define FSP_OP_EXIT 4'h1
`define FSP_OP_PW_PROG 4'h2
`define FSP_OP_PW_READ 4'h3
`define FSP_OP_PW_UNLOCK 4'h4
`define FSP_OP_PPB_PROG 4'h5
`define FSP_OP_PPB_ERASE 4'h6
`define FSP_OP_PPB_READ 4'h7
`define FSP_OP_FRZ_SET 4'h8
`define FSP_OP_FRZ_READ 4'h9
`define FSP_OP_DYB_SET 4'ha
`define FSP_OP_DYB_CLR 4'hb
`define FSP_OP_DYB_READ 4'hc
`define FSP_OP_ABORT_RST 4'hd

// command sets
`define FSP_SET_NONE 3'h0
`define FSP_SET_PW 3'h1
`define FSP_SET_PPB 3'h2
`define FSP_SET_FRZ 3'h3
`define FSP_SET_DYB 3'h4

// bus-cycle codes; the real values come from the command table
`define FSP_ADDR_UNLK1 24'h000555
`define FSP_ADDR_UNLK2 24'h0002aa
`define FSP_DATA_UNLK1 16'h00aa
`define FSP_DATA_UNLK2 16'h0055
`define FSP_CODE_ENT_PW 16'h0060
`define FSP_CODE_ENT_PPB 16'h00c0
`define FSP_CODE_ENT_FRZ 16'h0050
`define FSP_CODE_ENT_DYB 16'h00e0
`define FSP_CODE_EXIT1 16'h0090
`define FSP_CODE_EXIT2 16'h0000
`define FSP_CODE_PROG 16'h00a0
`define FSP_CODE_ERASE1 16'h0080
`define FSP_CODE_ERASE2 16'h0030
`define FSP_CODE_UNLK_A 16'h0025
`define FSP_CODE_UNLK_B 16'h0029
`define FSP_CODE_ABORT 16'h00f0
`define FSP_DYB_SET_CODE 16'h0000
`define FSP_DYB_CLR_CODE 16'h0001

`endif

//--- fsp_host.v
// host-side sequencer for the flash sector-protection command sets
// Functional notes
// - host always leaves a set by exit
// - each password piece gets its own program
// - piece address only low bits, upper zero
// - bad unlock needs buffer-abort reset command
// - host sends four pieces, then waits out the unlock time
// - dynamic codes 00h/01h on low byte
`timescale 1ns/1ps
`include "fsp_defines.vh"

module fsp_host #(
  parameter ADDR_W = 24,
  parameter SECT_W = 8,
  parameter PROG_WAIT_CYC = `FSP_PROG_WAIT_CYC,
  parameter ERASE_WAIT_CYC = `FSP_ERASE_WAIT_CYC
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // user command port
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [3:0] cmd_op,
  input wire [2:0] cmd_set,
  input wire [SECT_W-1:0] cmd_sector,
  input wire [1:0] cmd_piece,
  input wire [15:0] cmd_wdata,
  input wire [63:0] cmd_password,
  // user answer port
  output reg rsp_valid,
  output reg rsp_err,
  output reg [15:0] rsp_data,
  output reg [2:0] active_set,
  // flash bus
  output reg [ADDR_W-1:0] flash_addr,
  input wire [15:0] flash_dq_in,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n
);
  localparam [31:0] WP_CYC = `FSP_CYC_UP(`FSP_T_WP_NS);
  localparam [31:0] REC_CYC = `FSP_CYC_UP(`FSP_T_REC_NS);
  localparam [31:0] ACC_CYC = `FSP_CYC_UP(`FSP_T_ACC_NS);
  localparam [31:0] UNLOCK_CYC = `FSP_CYC_UP(`FSP_T_UNLOCK_NS);
  localparam [31:0] PROG_W = PROG_WAIT_CYC;
  localparam [31:0] ERASE_W = ERASE_WAIT_CYC;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_STEP = 3'h1;
  localparam [2:0] S_WLOW = 3'h2;
  localparam [2:0] S_RACC = 3'h3;
  localparam [2:0] S_REC = 3'h4;
  localparam [2:0] S_WAIT = 3'h5;
  localparam [2:0] S_RESP = 3'h6;
  reg [2:0] state;
  reg [31:0] cnt;
  reg [2:0] idx;
  reg [3:0] op_q;
  reg [2:0] set_q;
  reg [SECT_W-1:0] sect_q;
  reg [1:0] piece_q;
  reg [15:0] wdata_q;
  reg [63:0] pw_q;
  // step table, decoded from the latched operation
  reg st_rd;
  reg [ADDR_W-1:0] st_addr;
  reg [15:0] st_data;
  reg [2:0] last_idx;
  reg [31:0] wait_cyc;
  reg [ADDR_W-1:0] sect_addr;
  reg [ADDR_W-1:0] piece_addr;
  reg [15:0] entry_code;
  reg legal;
  reg [1:0] ul_piece;
  always @* begin
    sect_addr = {ADDR_W{1'b0}};
    sect_addr[16 +: SECT_W] = sect_q;
    piece_addr = {{(ADDR_W-2){1'b0}}, piece_q};
    ul_piece = idx[1:0] - 2'h1;
    case (set_q)
      `FSP_SET_PW: entry_code = `FSP_CODE_ENT_PW;
      `FSP_SET_PPB: entry_code = `FSP_CODE_ENT_PPB;
      `FSP_SET_FRZ: entry_code = `FSP_CODE_ENT_FRZ;
      default: entry_code = `FSP_CODE_ENT_DYB;
    endcase
    st_rd = 1'b0;
    st_addr = {ADDR_W{1'b0}};
    st_data = 16'h0000;
    last_idx = 3'h0;
    wait_cyc = 32'h0;
    case (op_q)
      `FSP_OP_ENTER, `FSP_OP_ABORT_RST: begin
        last_idx = 3'h2;
        st_addr = (idx == 3'h1) ? `FSP_ADDR_UNLK2 : `FSP_ADDR_UNLK1;
        if (idx == 3'h0)
          st_data = `FSP_DATA_UNLK1;
        else if (idx == 3'h1)
          st_data = `FSP_DATA_UNLK2;
        else
          st_data = (op_q == `FSP_OP_ENTER) ? entry_code : `FSP_CODE_ABORT;
      end
      `FSP_OP_EXIT: begin
        last_idx = 3'h1;
        st_data = (idx == 3'h0) ? `FSP_CODE_EXIT1 : `FSP_CODE_EXIT2;
      end
      `FSP_OP_PW_PROG: begin
        last_idx = 3'h1;
        wait_cyc = PROG_W;
        st_addr = (idx == 3'h0) ? {ADDR_W{1'b0}} : piece_addr;
        st_data = (idx == 3'h0) ? `FSP_CODE_PROG : wdata_q;
      end
      `FSP_OP_PW_READ: begin
        st_rd = 1'b1;
        st_addr = piece_addr;
      end
      `FSP_OP_PW_UNLOCK: begin
        last_idx = 3'h5;
        wait_cyc = UNLOCK_CYC;
        st_addr[1:0] = (idx == 3'h0 || idx == 3'h5) ? 2'h0 : ul_piece;
        st_data = pw_q[{ul_piece, 4'h0} +: 16];
        if (idx == 3'h0)
          st_data = `FSP_CODE_UNLK_A;
        if (idx == 3'h5)
          st_data = `FSP_CODE_UNLK_B;
      end
      `FSP_OP_PPB_PROG, `FSP_OP_DYB_SET, `FSP_OP_DYB_CLR: begin
        last_idx = 3'h1;
        wait_cyc = (op_q == `FSP_OP_PPB_PROG) ? PROG_W : 32'h0;
        st_addr = (idx == 3'h0) ? {ADDR_W{1'b0}} : sect_addr;
        st_data = (idx == 3'h0) ? `FSP_CODE_PROG :
          (op_q == `FSP_OP_DYB_CLR) ? `FSP_DYB_CLR_CODE :
          `FSP_DYB_SET_CODE;
      end
      `FSP_OP_PPB_ERASE: begin
        last_idx = 3'h1;
        wait_cyc = ERASE_W;
        st_data = (idx == 3'h0) ? `FSP_CODE_ERASE1 : `FSP_CODE_ERASE2;
      end
      `FSP_OP_FRZ_SET: begin
        last_idx = 3'h1;
        st_data = (idx == 3'h0) ? `FSP_CODE_PROG : 16'h0000;
      end
      `FSP_OP_FRZ_READ: st_rd = 1'b1;
      `FSP_OP_PPB_READ, `FSP_OP_DYB_READ: begin
        st_rd = 1'b1;
        st_addr = sect_addr;
      end
      default: st_rd = 1'b0;
    endcase
  end
  // one set at a time, and each operation only inside its own set, except abort reset, which is taken anywhere
  always @* begin
    case (cmd_op)
      `FSP_OP_ENTER: legal = (active_set == `FSP_SET_NONE) &&
        (cmd_set != `FSP_SET_NONE) && (cmd_set <= `FSP_SET_DYB);
      `FSP_OP_EXIT: legal = (active_set != `FSP_SET_NONE);
      `FSP_OP_ABORT_RST: legal = 1'b1;
      `FSP_OP_PW_PROG, `FSP_OP_PW_READ, `FSP_OP_PW_UNLOCK:
        legal = (active_set == `FSP_SET_PW);
      `FSP_OP_PPB_PROG, `FSP_OP_PPB_ERASE, `FSP_OP_PPB_READ:
        legal = (active_set == `FSP_SET_PPB);
      `FSP_OP_FRZ_SET, `FSP_OP_FRZ_READ:
        legal = (active_set == `FSP_SET_FRZ);
      `FSP_OP_DYB_SET, `FSP_OP_DYB_CLR, `FSP_OP_DYB_READ:
        legal = (active_set == `FSP_SET_DYB);
      default: legal = 1'b0;
    endcase
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      cnt <= 32'h0;
      idx <= 3'h0;
      op_q <= 4'h0;
      set_q <= 3'h0;
      sect_q <= {SECT_W{1'b0}};
      piece_q <= 2'h0;
      wdata_q <= 16'h0000;
      pw_q <= 64'h0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 16'h0000;
      active_set <= `FSP_SET_NONE;
      flash_addr <= {ADDR_W{1'b0}};
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          rsp_valid <= 1'b0;
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            rsp_err <= ~legal;
            op_q <= cmd_op;
            set_q <= cmd_set;
            sect_q <= cmd_sector;
            piece_q <= cmd_piece;
            wdata_q <= cmd_wdata;
            pw_q <= cmd_password;
            idx <= 3'h0;
            state <= legal ? S_STEP : S_RESP;
          end
        end
        S_STEP: begin
          flash_addr <= st_addr;
          flash_ce_n <= 1'b0;
          if (st_rd) begin
            flash_oe_n <= 1'b0;
            cnt <= ACC_CYC;
            state <= S_RACC;
          end else begin
            flash_dq_out <= st_data;
            flash_dq_oe <= 1'b1;
            flash_we_n <= 1'b0;
            cnt <= WP_CYC;
            state <= S_WLOW;
          end
        end
        S_WLOW: begin
          if (cnt == 32'h1) begin
            // data is taken on this rising edge, so it stays driven
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= REC_CYC;
            state <= S_REC;
          end else
            cnt <= cnt - 32'h1;
        end
        S_RACC: begin
          if (cnt == 32'h1) begin
            rsp_data <= flash_dq_in;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= REC_CYC;
            state <= S_REC;
          end else
            cnt <= cnt - 32'h1;
        end
        S_REC: begin
          if (cnt == 32'h1) begin
            flash_dq_oe <= 1'b0;
            if (idx == last_idx) begin
              cnt <= wait_cyc;
              state <= (wait_cyc == 32'h0) ? S_RESP : S_WAIT;
            end else begin
              idx <= idx + 3'h1;
              state <= S_STEP;
            end
          end else
            cnt <= cnt - 32'h1;
        end
        S_WAIT: begin
          // busy here, so no second unlock can start inside the window
          if (cnt == 32'h1)
            state <= S_RESP;
          else
            cnt <= cnt - 32'h1;
        end
        S_RESP: begin
          rsp_valid <= 1'b1;
          state <= S_IDLE;
          if (!rsp_err && op_q == `FSP_OP_ENTER)
            active_set <= set_q;
          else if (!rsp_err && op_q == `FSP_OP_EXIT)
            active_set <= `FSP_SET_NONE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

//--- fsp_host_chk.sv
// assertions on the ports of the protection sequencer
`timescale 1ns/1ps
module fsp_host_chk #(
  parameter ADDR_W = 24
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // user side
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [3:0] cmd_op,
  input wire rsp_valid,
  input wire rsp_err,
  // flash bus
  input wire [ADDR_W-1:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_take; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
  a_take: assert property (p_take) else $error("busy not shown");
  property p_ref;
    cmd_valid && cmd_ready && cmd_op[3:1] == 3'h7 |-> ##[2:3] rsp_err;
  endproperty
  a_ref: assert property (p_ref) else $error("bad op taken");
  property p_rdy; rsp_valid |=> cmd_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("not idle after answer");
  property p_wp;
    $fell(flash_we_n) |=> (!flash_we_n)[*8] ##1 flash_we_n;
  endproperty
  a_wp: assert property (p_wp) else $error("write pulse width");
  property p_wdrv;
    !flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n;
  endproperty
  a_wdrv: assert property (p_wdrv) else $error("write not driven");
  property p_wst;
    !flash_we_n && !$past(flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_wst: assert property (p_wst) else $error("write data moved");
  property p_acc; $fell(flash_oe_n) |-> ##28 flash_oe_n; endproperty
  a_acc: assert property (p_acc) else $error("read access length");
  property p_rd;
    $fell(flash_oe_n) |-> !flash_ce_n && !flash_dq_oe && flash_we_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read with bus driven");
endmodule

bind fsp_host fsp_host_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid(rsp_valid),
  .rsp_err(rsp_err), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

//--- fsp_flash_mdl.sv
// behavioural flash protection logic answering the host
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_flash_mdl (
  // flash bus
  input wire [23:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  output wire [15:0] flash_dq_in
);
  reg [15:0] pw [0:3];
  reg [15:0] pin [0:3];
  reg [255:0] persistent_protect_bit;
  reg [255:0] dynamic_protect_bit;
  reg frz = 0;
  reg [2:0] set = 0;
  reg [15:0] prev = 0;
  reg [15:0] p;
  reg [2:0] ucnt = 0;
  reg [15:0] q;
  wire [15:0] d = flash_dq_out;
  wire [7:0] sc = flash_addr[23:16];
  initial begin
    pw[0] = 16'hffff;
    pw[1] = 16'hffff;
    pw[2] = 16'hffff;
    pw[3] = 16'hffff;
    persistent_protect_bit = 0;
    dynamic_protect_bit = 0;
  end
  // writes land on the rising write strobe, as on the real part
  always @(posedge flash_we_n) begin
    p = (prev == `FSP_CODE_PROG) ? 16'h0 : d;
    if (ucnt != 0) begin
      if (ucnt < 5) pin[flash_addr[1:0]] = d;
      else if (d == `FSP_CODE_UNLK_B && pin[0] == pw[0] && pin[1] == pw[1]
               && pin[2] == pw[2] && pin[3] == pw[3]) frz = 0;
      ucnt = (ucnt == 5) ? 3'h0 : ucnt + 3'h1;
    end else if (prev == `FSP_DATA_UNLK2) begin
      case (d)
        `FSP_CODE_ENT_PW: set = `FSP_SET_PW;
        `FSP_CODE_ENT_PPB: set = `FSP_SET_PPB;
        `FSP_CODE_ENT_FRZ: set = `FSP_SET_FRZ;
        `FSP_CODE_ENT_DYB: set = `FSP_SET_DYB;
        default: ;
      endcase
    end else if (prev == `FSP_CODE_EXIT1 && d == `FSP_CODE_EXIT2) begin
      set = `FSP_SET_NONE;
    end else if (prev == `FSP_CODE_PROG) begin
      case (set)
        `FSP_SET_PW: if (flash_addr[23:2] == 0)
          pw[flash_addr[1:0]] = pw[flash_addr[1:0]] & d;
        `FSP_SET_PPB: if (!frz) persistent_protect_bit[sc] = 1'b1;
        `FSP_SET_FRZ: frz = 1'b1;
        `FSP_SET_DYB: if (d[7:0] < 8'h2) dynamic_protect_bit[sc] = !d[0];
        default: ;
      endcase
    end else if (prev == `FSP_CODE_ERASE1 && d == `FSP_CODE_ERASE2) begin
      if (set == `FSP_SET_PPB && !frz) persistent_protect_bit = 0;
    end else if (d == `FSP_CODE_UNLK_A && set == `FSP_SET_PW) begin
      ucnt = 3'h1;
    end
    prev = p;
  end
  always_comb begin
    case (set)
      `FSP_SET_PW: q = pw[flash_addr[1:0]];
      `FSP_SET_PPB: q = {15'h0, persistent_protect_bit[sc]};
      `FSP_SET_FRZ: q = {15'h0, frz};
      `FSP_SET_DYB: q = {15'h0, dynamic_protect_bit[sc]};
      default: q = 16'h0;
    endcase
  end
  // a released bus shows garbage, never the last value
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? q : ~q;
endmodule

//--- flash_sector_protection_cmds_tb_top.sv
// self-checking bench for the protection sequencer
`timescale 1ns/1ps
`include "fsp_defines.vh"
module flash_sector_protection_cmds_tb_top;
  reg clk = 0;
  reg sys_rst = 1;
  reg cmd_valid = 0;
  reg [3:0] cmd_op = 0;
  reg [2:0] cmd_set = 0;
  reg [7:0] cmd_sector = 0;
  reg [1:0] cmd_piece = 0;
  reg [15:0] cmd_wdata = 0;
  reg [63:0] cmd_password = 0;
  wire cmd_ready, rsp_valid, rsp_err, oe, ce_n, oe_n, we_n;
  wire [15:0] rsp_data, dq_in, dq_out;
  wire [2:0] active_set;
  wire [23:0] addr;
  integer n_mismatch = 0;
  integer checks = 0;
  integer cyc = 0;
  always #2 clk = ~clk;
  fsp_host #(.PROG_WAIT_CYC(20), .ERASE_WAIT_CYC(20)) dut (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_set(cmd_set), .cmd_sector(cmd_sector),
    .cmd_piece(cmd_piece), .cmd_wdata(cmd_wdata),
    .cmd_password(cmd_password), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_data(rsp_data), .active_set(active_set), .flash_addr(addr),
    .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(oe),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  fsp_flash_mdl mdl (.flash_addr(addr), .flash_dq_out(dq_out),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_in(dq_in));
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  task chk(input [39:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task go(input [3:0] o, input [2:0] s, input [7:0] sc, input [15:0] wd,
    input e);
    begin
      while (cmd_ready !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      cmd_op = o;
      cmd_set = s;
      cmd_sector = sc;
      cmd_piece = sc[1:0];
      cmd_wdata = wd;
      cmd_valid = 1;
      @(posedge clk);
      #1;
      cmd_valid = 0;
      while (rsp_valid !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      chk("err", {15'h0, rsp_err}, {15'h0, e});
    end
  endtask
  task rd(input [3:0] o, input [7:0] sc, input [15:0] x);
    begin
      go(o, 0, sc, 0, 0);
      chk("rdata", rsp_data, x);
    end
  endtask
  task unlock(input [63:0] v);
    begin
      cmd_password = v;
      go(`FSP_OP_ENTER, `FSP_SET_PW, 0, 0, 0);
      go(`FSP_OP_PW_UNLOCK, 0, 0, 0, 0);
      go(`FSP_OP_EXIT, 0, 0, 0, 0);
    end
  endtask
  task frz(input [15:0] x, input s);
    begin
      go(`FSP_OP_ENTER, `FSP_SET_FRZ, 0, 0, 0);
      if (s) go(`FSP_OP_FRZ_SET, 0, 0, 0, 0);
      rd(`FSP_OP_FRZ_READ, 0, x);
      go(`FSP_OP_EXIT, 0, 0, 0, 0);
    end
  endtask
  task t_pw;
    begin
      go(`FSP_OP_ENTER, `FSP_SET_PW, 0, 0, 0);
      chk("set", {13'h0, active_set}, 16'h1);
      rd(`FSP_OP_PW_READ, 2, 16'hffff);
      go(`FSP_OP_PW_PROG, 0, 2, 16'h1234, 0);
      rd(`FSP_OP_PW_READ, 2, 16'h1234);
      go(`FSP_OP_PW_PROG, 0, 2, 16'hffff, 0);
      rd(`FSP_OP_PW_READ, 2, 16'h1234);
      go(`FSP_OP_PW_PROG, 0, 0, 16'h0000, 0);
      go(`FSP_OP_ENTER, `FSP_SET_DYB, 0, 0, 1);
      go(`FSP_OP_PPB_READ, 0, 0, 0, 1);
      go(4'he, 0, 0, 0, 1);
      go(`FSP_OP_EXIT, 0, 0, 0, 0);
      go(`FSP_OP_EXIT, 0, 0, 0, 1);
      go(`FSP_OP_ABORT_RST, 0, 0, 0, 0);
    end
  endtask
  task t_ppb;
    begin
      frz(16'h1, 1);
      go(`FSP_OP_ENTER, `FSP_SET_PPB, 0, 0, 0);
      go(`FSP_OP_PPB_PROG, 0, 5, 0, 0);
      rd(`FSP_OP_PPB_READ, 5, 16'h0);
      go(`FSP_OP_EXIT, 0, 0, 0, 0);
      unlock(64'hffff_1234_ffff_0001);
      frz(16'h1, 0);
      unlock(64'hffff_1234_ffff_0000);
      frz(16'h0, 0);
      go(`FSP_OP_ENTER, `FSP_SET_PPB, 0, 0, 0);
      go(`FSP_OP_PPB_PROG, 0, 5, 0, 0);
      rd(`FSP_OP_PPB_READ, 5, 16'h1);
      rd(`FSP_OP_PPB_READ, 6, 16'h0);
      go(`FSP_OP_PPB_ERASE, 0, 0, 0, 0);
      rd(`FSP_OP_PPB_READ, 5, 16'h0);
      go(`FSP_OP_EXIT, 0, 0, 0, 0);
      frz(16'h1, 1);
    end
  endtask
  task t_dyb;
    begin
      go(`FSP_OP_ENTER, `FSP_SET_DYB, 0, 0, 0);
      go(`FSP_OP_DYB_SET, 0, 3, 0, 0);
      rd(`FSP_OP_DYB_READ, 3, 16'h1);
      rd(`FSP_OP_DYB_READ, 4, 16'h0);
      go(`FSP_OP_DYB_CLR, 0, 3, 0, 0);
      rd(`FSP_OP_DYB_READ, 3, 16'h0);
      go(`FSP_OP_EXIT, 0, 0, 0, 0);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 0;
    t_pw;
    t_ppb;
    t_dyb;
    report_and_stop;
  end
endmodule
